// >>> verilog/cam_frame_capture.sv
// camera frame capture control: registers, thinning, interrupt status, pixel output
`timescale 1ns/10ps
module cam_frame_capture
    import cam_capture_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [cam_capture_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cam_capture_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [cam_capture_pkg::DATA_W-1:0] reg_rdata,
    input wire logic camera_pixel_clock_in,
    input wire logic camera_frame_valid_in,
    input wire logic camera_line_valid_in,
    input wire logic [cam_capture_pkg::BYTE_W-1:0] camera_byte_in,
    output logic [cam_capture_pkg::PIXEL_W-1:0] resizer_pixel_out,
    output logic resizer_write_out,
    output logic resizer_line_valid_out,
    output logic resizer_frame_valid_out,
    output logic frame_interrupt
);
    import cam_capture_pkg::*;

    // register storage
    logic [DATA_W-1:0] mode_reg; // port enable, fast sampling
    logic [DATA_W-1:0] frame_ctrl_reg; // interrupt and thinning control
    logic [DATA_W-1:0] rdata_reg; // read data, valid the cycle after a read
    // capture state
    cap_state_type state_reg;
    cap_state_type state_next;
    logic run_reg; // capture start/stop flag
    logic irq_reg; // pending frame interrupt
    logic [ERR_FLAGS-1:0] err_reg; // stream error flags
    logic shutter_reg; // shutter event seen since enable
    logic end_pending_reg; // capture ended, waiting for last edge
    logic [THIN_W-1:0] thin_cnt_reg; // frames since last kept one
    logic effective_reg; // current frame survives thinning
    logic fv_prev_reg; // last frame-valid level
    logic lv_prev_reg; // last line-valid level
    // pixel assembly
    logic [1:0] phase_reg; // byte position in Cb Y Cr Y group
    logic [BYTE_W-1:0] cb_reg;
    logic [BYTE_W-1:0] y0_reg;
    logic [BYTE_W-1:0] cr_reg;
    logic [PIXEL_W-1:0] pixel_reg;
    logic wr_reg;
    logic lv_out_reg;
    logic fv_out_reg;

    // synchronised camera side
    logic byte_stb;
    logic [BYTE_W-1:0] byte_val;
    logic cam_fv;
    logic cam_lv;

    cam_link_sampler u_sampler (
        .clk(clk),
        .nrst(nrst),
        .fast_mode(mode_reg[MODE_FAST_SAMPLE]),
        .pixel_clock_in(camera_pixel_clock_in),
        .frame_valid_in(camera_frame_valid_in),
        .line_valid_in(camera_line_valid_in),
        .byte_in(camera_byte_in),
        .byte_stb(byte_stb),
        .byte_out(byte_val),
        .frame_valid(cam_fv),
        .line_valid(cam_lv)
    );

    // address decode and command strobes
    wire wr_mode = reg_write & (reg_addr == OFS_MODE);
    wire wr_fc = reg_write & (reg_addr == OFS_FRAME_CTRL);
    wire wr_cmd = reg_write & (reg_addr == OFS_COMMAND);
    wire cmd_soft_reset = wr_cmd & reg_wdata[CMD_SOFT_RESET];
    wire cmd_irq_clear = wr_cmd & reg_wdata[CMD_IRQ_CLEAR];
    wire cmd_start = wr_cmd & reg_wdata[CMD_START];
    wire cmd_stop = wr_cmd & reg_wdata[CMD_STOP];
    wire [ERR_FLAGS-1:0] cmd_err_clear = {ERR_FLAGS{wr_cmd}} & reg_wdata[CMD_ERR0_CLEAR +: ERR_FLAGS];

    // mode and frame control fields
    wire port_en = mode_reg[MODE_PORT_EN];
    wire irq_en = frame_ctrl_reg[FC_IRQ_EN];
    wire irq_pol = frame_ctrl_reg[FC_IRQ_POL];
    wire [THIN_W-1:0] thin_code = frame_ctrl_reg[FC_THIN_HI:FC_THIN_LO];
    wire shutter_dis = frame_ctrl_reg[FC_SHUTTER_DIS];
    wire single_mode = frame_ctrl_reg[FC_SINGLE];
    wire irq_ctrl = frame_ctrl_reg[FC_IRQ_CTRL];

    // frame edges
    wire fv_rise = cam_fv & ~fv_prev_reg;
    wire fv_fall = ~cam_fv & fv_prev_reg;
    wire lv_fall = ~cam_lv & lv_prev_reg;
    wire irq_edge = irq_pol ? fv_rise : fv_fall;

    // thinning: keep when the counter wraps to zero, never for the drop-all code
    wire [THIN_W-1:0] thin_last = (thin_code == THIN_RESERVED) ? THIN_NONE : thin_code;
    wire keep_frame = (thin_code != THIN_ALL) & (thin_cnt_reg == THIN_NONE);
    wire forward_start = fv_rise & port_en & run_reg & keep_frame;
    wire fwd = (state_reg == CAP_FORWARD);
    wire fwd_end = fwd & fv_fall;
    // frame whose edge may raise the per-frame interrupt
    wire fwd_edge = irq_pol ? forward_start : fwd_end;

    // interrupt sources
    wire shutter_ok = shutter_dis | shutter_reg;
    wire frame_event = ~irq_ctrl & irq_en & fwd_edge & shutter_ok;
    wire end_event = irq_ctrl & end_pending_reg & irq_edge;

    // stream error events: odd byte count at line end, frame end inside a line
    wire [ERR_FLAGS-1:0] err_event = {fv_fall & cam_lv, lv_fall & phase_reg[0]};

    // capture sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CAP_IDLE: begin
                if (fv_rise) begin
                    state_next = forward_start ? CAP_FORWARD : CAP_SKIP;
                end
            end
            CAP_FORWARD: begin
                if (fv_fall) begin
                    state_next = CAP_IDLE;
                end
            end
            CAP_SKIP: begin
                if (fv_fall) begin
                    state_next = CAP_IDLE;
                end
            end
        endcase
    end

    // software registers; soft reset touches only the port-enable bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= MODE_RESET;
            frame_ctrl_reg <= FRAME_CTRL_RESET;
        end else begin
            if (cmd_soft_reset) begin
                mode_reg[MODE_PORT_EN] <= 1'b0;
            end else if (wr_mode) begin
                mode_reg <= reg_wdata;
            end
            // the single-frame bit must stay put while enabled; the write below takes the whole register at any time
            if (wr_fc) begin
                frame_ctrl_reg <= reg_wdata;
            end
        end
    end

    // capture state, run flag, shutter and end tracking
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= CAP_IDLE;
            run_reg <= 1'b1;
            shutter_reg <= 1'b0;
            end_pending_reg <= 1'b0;
        end else if (cmd_soft_reset) begin
            state_reg <= CAP_IDLE;
            run_reg <= ~cmd_stop;
            shutter_reg <= 1'b0;
            end_pending_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (cmd_start) begin
                run_reg <= 1'b1;
            end else if (cmd_stop) begin
                run_reg <= 1'b0;
            end else if (fwd_end & single_mode) begin
                run_reg <= 1'b0;
            end
            // start command stands for the shutter event
            if (cmd_start) begin
                shutter_reg <= 1'b1;
            end else if (!port_en) begin
                shutter_reg <= 1'b0;
            end
            // port-enable written low arms the one end-of-capture interrupt
            if (wr_mode & port_en & ~reg_wdata[MODE_PORT_EN]) begin
                end_pending_reg <= 1'b1;
            end else if (irq_edge) begin
                end_pending_reg <= 1'b0;
            end
        end
    end

    // thinning counter advances once per frame
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thin_cnt_reg <= THIN_NONE;
            effective_reg <= 1'b0;
        end else if (cmd_soft_reset) begin
            thin_cnt_reg <= THIN_NONE;
            effective_reg <= 1'b0;
        end else if (fv_rise) begin
            effective_reg <= keep_frame;
            thin_cnt_reg <= (thin_cnt_reg >= thin_last) ? THIN_NONE : thin_cnt_reg + 3'h1;
        end
    end

    // pending interrupt: a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else if (frame_event | end_event) begin
            irq_reg <= 1'b1;
        end else if (cmd_irq_clear | cmd_soft_reset) begin
            irq_reg <= 1'b0;
        end
    end

    // error flags, one per bit; set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < ERR_FLAGS; gi++) begin : g_err
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    err_reg[gi] <= 1'b0;
                end else if (err_event[gi]) begin
                    err_reg[gi] <= 1'b1;
                end else if (cmd_err_clear[gi] | cmd_soft_reset) begin
                    err_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // 4:2:2 byte groups to 4:4:4 pixels, Cb Y Cr Y order
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fv_prev_reg <= 1'b0;
            lv_prev_reg <= 1'b0;
            phase_reg <= 2'h0;
            cb_reg <= '0;
            y0_reg <= '0;
            cr_reg <= '0;
            pixel_reg <= '0;
            wr_reg <= 1'b0;
            lv_out_reg <= 1'b0;
            fv_out_reg <= 1'b0;
        end else begin
            fv_prev_reg <= cam_fv;
            lv_prev_reg <= cam_lv;
            wr_reg <= 1'b0;
            fv_out_reg <= fwd & cam_fv;
            lv_out_reg <= fwd & cam_lv;
            if (!cam_lv) begin
                phase_reg <= 2'h0; // each line starts on a chroma byte
            end else if (byte_stb) begin
                phase_reg <= phase_reg + 2'h1;
                unique case (phase_reg)
                    2'h0: cb_reg <= byte_val;
                    2'h1: y0_reg <= byte_val;
                    2'h2: begin
                        cr_reg <= byte_val;
                        pixel_reg <= {y0_reg, cb_reg, byte_val};
                        wr_reg <= fwd;
                    end
                    2'h3: begin
                        pixel_reg <= {byte_val, cb_reg, cr_reg};
                        wr_reg <= fwd;
                    end
                endcase
            end
        end
    end

    // status word and read mux
    wire [DATA_W-1:0] status_word = {6'h00, err_reg, 1'b0, cam_fv, 1'b0, effective_reg,
                                     fwd, run_reg, irq_reg, 1'b0};
    wire [DATA_W-1:0] read_mux = (reg_addr == OFS_MODE) ? mode_reg :
                                 (reg_addr == OFS_FRAME_CTRL) ? frame_ctrl_reg :
                                 (reg_addr == OFS_STATUS) ? status_word : 16'h0000;

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= reg_read ? read_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_reg;
    assign resizer_pixel_out = pixel_reg;
    assign resizer_write_out = wr_reg;
    assign resizer_line_valid_out = lv_out_reg;
    assign resizer_frame_valid_out = fv_out_reg;
    assign frame_interrupt = irq_reg;
endmodule : cam_frame_capture

// >>> pkg/cam_capture_pkg.sv
// constants, register map and field layout of the camera frame capture port
package cam_capture_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_FRAME_CTRL = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h2c;
    // reset values
    localparam logic [DATA_W-1:0] MODE_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] FRAME_CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0004;
    // mode register fields
    localparam int MODE_PORT_EN = 0;
    localparam int MODE_FAST_SAMPLE = 10;
    // frame control register fields
    localparam int FC_IRQ_EN = 0;
    localparam int FC_IRQ_POL = 1;
    localparam int FC_THIN_LO = 2;
    localparam int FC_THIN_HI = 4;
    localparam int FC_SHUTTER_DIS = 5;
    localparam int FC_SINGLE = 6;
    localparam int FC_IRQ_CTRL = 7;
    // command register fields
    localparam int CMD_SOFT_RESET = 0;
    localparam int CMD_IRQ_CLEAR = 1;
    localparam int CMD_START = 2;
    localparam int CMD_STOP = 3;
    localparam int CMD_ERR0_CLEAR = 8;
    // status register fields
    localparam int ST_IRQ = 1;
    localparam int ST_RUN = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_EFFECTIVE = 4;
    localparam int ST_VSYNC = 6;
    localparam int ST_ERR0 = 8;
    // frame thinning codes
    localparam int THIN_W = 3;
    localparam logic [THIN_W-1:0] THIN_NONE = 3'h0;
    localparam logic [THIN_W-1:0] THIN_RESERVED = 3'h6;
    localparam logic [THIN_W-1:0] THIN_ALL = 3'h7;
    // pixel widths and error flag count
    localparam int BYTE_W = 8;
    localparam int PIXEL_W = 24;
    localparam int ERR_FLAGS = 2;
    // capture state
    typedef enum logic [1:0] {CAP_IDLE, CAP_FORWARD, CAP_SKIP} cap_state_type;
endpackage : cam_capture_pkg

// >>> verilog/cam_link_sampler.sv
// samples camera pixel clock, strobes and byte data into the internal clock domain
`timescale 1ns/10ps
module cam_link_sampler
    import cam_capture_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic fast_mode,
    input wire logic pixel_clock_in,
    input wire logic frame_valid_in,
    input wire logic line_valid_in,
    input wire logic [cam_capture_pkg::BYTE_W-1:0] byte_in,
    output logic byte_stb,
    output logic [cam_capture_pkg::BYTE_W-1:0] byte_out,
    output logic frame_valid,
    output logic line_valid
);
    import cam_capture_pkg::*;

    localparam int SYNC_W = BYTE_W + 3;

    logic [SYNC_W-1:0] meta_reg; // first synchroniser stage, read only by sync_reg
    logic [SYNC_W-1:0] sync_reg; // second synchroniser stage
    logic pclk_prev_reg; // last sampled pixel clock level
    logic [BYTE_W-1:0] slot_reg [2]; // two sampling circuits
    logic slot_sel_reg; // which circuit takes the next byte
    logic rd_sel_reg; // which circuit feeds the output
    logic stb_reg;
    logic fv_reg;
    logic lv_reg;
    wire pclk_s = sync_reg[SYNC_W-1];
    wire pclk_rise = pclk_s & ~pclk_prev_reg;
    wire take = pclk_rise & sync_reg[BYTE_W];  // only bytes inside a valid line

    // two flops on everything that comes from the camera
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            pclk_prev_reg <= 1'b0;
        end else begin
            meta_reg <= {pixel_clock_in, frame_valid_in, line_valid_in, byte_in};
            sync_reg <= meta_reg;
            pclk_prev_reg <= pclk_s;
        end
    end

    // byte capture on the pixel clock rising edge; fast mode alternates circuits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slot_reg[0] <= '0;
            slot_reg[1] <= '0;
            slot_sel_reg <= 1'b0;
            rd_sel_reg <= 1'b0;
            stb_reg <= 1'b0;
            fv_reg <= 1'b0;
            lv_reg <= 1'b0;
        end else begin
            stb_reg <= take;
            fv_reg <= sync_reg[BYTE_W+1];
            lv_reg <= sync_reg[BYTE_W];
            if (take) begin
                slot_reg[slot_sel_reg] <= sync_reg[BYTE_W-1:0];
                rd_sel_reg <= slot_sel_reg;
            end
            // circuits toggle every cycle in fast mode, single circuit otherwise
            slot_sel_reg <= fast_mode ? ~slot_sel_reg : 1'b0;
        end
    end

    assign byte_stb = stb_reg;
    assign byte_out = slot_reg[rd_sel_reg];
    assign frame_valid = fv_reg;
    assign line_valid = lv_reg;
endmodule : cam_link_sampler

// >>> sim/cam_frame_capture_assertions.sv
// property checker bound to the camera frame capture port
`timescale 1ns/10ps
module cam_frame_capture_assertions
    import cam_capture_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [cam_capture_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cam_capture_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [cam_capture_pkg::DATA_W-1:0] reg_rdata,
    input wire logic camera_pixel_clock_in,
    input wire logic camera_frame_valid_in,
    input wire logic camera_line_valid_in,
    input wire logic [cam_capture_pkg::BYTE_W-1:0] camera_byte_in,
    input wire logic [cam_capture_pkg::PIXEL_W-1:0] resizer_pixel_out,
    input wire logic resizer_write_out,
    input wire logic resizer_line_valid_out,
    input wire logic resizer_frame_valid_out,
    input wire logic frame_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic en_reg; // shadow of the port enable bit
    logic [7:0] fc_reg; // shadow of the frame control bits
    logic [3:0] off_reg; // cycles since the port was disabled, saturating
    wire cmd_wr = reg_write && reg_addr == OFS_COMMAND;
    wire clr_wr = cmd_wr && (reg_wdata[CMD_IRQ_CLEAR] || reg_wdata[CMD_SOFT_RESET]);
    wire mode_wr = reg_write && reg_addr == OFS_MODE;
    wire en_next = mode_wr ? reg_wdata[MODE_PORT_EN] : en_reg && !(cmd_wr && reg_wdata[CMD_SOFT_RESET]);
    // shadows follow the register writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_reg <= 1'b0;
            fc_reg <= 8'h00;
            off_reg <= 4'h0;
        end else begin
            en_reg <= en_next;
            fc_reg <= (reg_write && reg_addr == OFS_FRAME_CTRL) ? reg_wdata[7:0] : fc_reg;
            off_reg <= en_reg ? 4'h0 : off_reg + {3'h0, off_reg != 4'hf};
        end
    end
    // a pixel strobe is followed by a quiet stretch
    sequence s_quiet7;
        !resizer_write_out [*7];
    endsequence
    property p_write_pulse;
        resizer_write_out |=> s_quiet7;
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("pixel strobe too close");
    property p_write_in_frame;
        resizer_write_out |-> resizer_frame_valid_out;
    endproperty
    a_write_in_frame: assert property (p_write_in_frame) else $error("pixel outside frame");
    property p_write_in_line;
        resizer_write_out |-> resizer_line_valid_out;
    endproperty
    a_write_in_line: assert property (p_write_in_line) else $error("pixel outside line");
    property p_off_quiet;
        off_reg == 4'hf |-> !resizer_write_out;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("pixel while disabled");
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_status_rsv;
        reg_read && reg_addr == OFS_STATUS |=> (reg_rdata & 16'hfca1) == 16'h0000;
    endproperty
    a_status_rsv: assert property (p_status_rsv) else $error("status spare bits set");
    property p_cmd_read;
        reg_read && reg_addr == OFS_COMMAND |=> reg_rdata == 16'h0000;
    endproperty
    a_cmd_read: assert property (p_cmd_read) else $error("command read not zero");
    property p_irq_fall;
        $fell(frame_interrupt) |-> $past(clr_wr);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped unasked");
    property p_irq_cause;
        $rose(frame_interrupt) |-> fc_reg[FC_IRQ_EN] || fc_reg[FC_IRQ_CTRL];
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt while gated");
endmodule : cam_frame_capture_assertions
bind cam_frame_capture cam_frame_capture_assertions u_cam_frame_capture_assertions (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .camera_pixel_clock_in(camera_pixel_clock_in),
    .camera_frame_valid_in(camera_frame_valid_in), .camera_line_valid_in(camera_line_valid_in),
    .camera_byte_in(camera_byte_in), .resizer_pixel_out(resizer_pixel_out),
    .resizer_write_out(resizer_write_out), .resizer_line_valid_out(resizer_line_valid_out),
    .resizer_frame_valid_out(resizer_frame_valid_out), .frame_interrupt(frame_interrupt));

// >>> sim/camera_source_model.sv
// camera module model: pixel clock, strobes and Cb Y Cr Y bytes
`timescale 1ns/10ps
module camera_source_model
    import cam_capture_pkg::*;
(
    output logic pixel_clock,
    output logic frame_valid,
    output logic line_valid,
    output logic [cam_capture_pkg::BYTE_W-1:0] byte_data
);
    int seed = 29720; // fixed seed of the byte stream
    logic [PIXEL_W-1:0] exp_q[$]; // pixels the resizer must receive
    logic [BYTE_W-1:0] b [4]; // one Cb Y Cr Y group
    // idle camera: clock low, strobes inactive
    initial begin
        pixel_clock = 1'b0;
        frame_valid = 1'b0;
        line_valid = 1'b0;
        byte_data = 8'h5a;
    end
    // one 160 ns pixel clock period, eight internal clocks
    task automatic tick();
        #80 pixel_clock = 1'b1;
        #80 pixel_clock = 1'b0;
    endtask : tick
    // one frame; bytes change on the falling edge, fwd notes the expected pixels
    task automatic frame(input int lines, input int n, input bit fwd);
        #7 frame_valid = 1'b1;
        repeat (2) tick();
        for (int l = 0; l < lines; l++) begin
            for (int i = 0; i < n; i++) begin
                b[i % 4] = BYTE_W'($random(seed));
                byte_data = b[i % 4];
                line_valid = 1'b1;
                tick();
                if (fwd && i % 4 == 2) exp_q.push_back({b[1], b[0], b[2]});
                if (fwd && i % 4 == 3) exp_q.push_back({b[3], b[0], b[2]});
            end
            line_valid = 1'b0;
            byte_data = ~byte_data; // released bus shows no stale byte
            repeat (2) tick();
        end
        frame_valid = 1'b0;
        tick();
    endtask : frame
endmodule : camera_source_model

// >>> sim/camera_frame_capture_tb.sv
// self-checking bench of the camera frame capture port
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module camera_frame_capture_tb;
    import cam_capture_pkg::*;
    logic clk, nrst, reg_write, reg_read, frame_interrupt, wr_out, lv_out, fv_out, pclk, fv, lv;
    logic rd_pend = 1'b0; // a read is awaiting its data
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [BYTE_W-1:0] cam_byte;
    logic [PIXEL_W-1:0] pix;
    logic [PIXEL_W-1:0] pix_e; // oldest expected pixel
    logic [31:0] rd_q[$]; // mask and expected word of each read
    logic [31:0] rd_e;
    int num_errors = 0;
    int checks = 0;
    int n;
    cam_frame_capture u_cam_frame_capture (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .camera_pixel_clock_in(pclk),
        .camera_frame_valid_in(fv), .camera_line_valid_in(lv), .camera_byte_in(cam_byte),
        .resizer_pixel_out(pix), .resizer_write_out(wr_out), .resizer_line_valid_out(lv_out),
        .resizer_frame_valid_out(fv_out), .frame_interrupt(frame_interrupt));
    camera_source_model u_camera_source_model (.pixel_clock(pclk), .frame_valid(fv), .line_valid(lv),
        .byte_data(cam_byte));
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // compares read words and pixels with the oldest notes
    always @(posedge clk) begin
        rd_pend <= reg_read;
        if (rd_pend === 1'b1) begin
            rd_e = rd_q.pop_front();
            `CHK(reg_rdata & rd_e[31:16], rd_e[15:0])
        end
        if (wr_out === 1'b1) begin
            `CHK(u_camera_source_model.exp_q.size() != 0, 1'b1)
            if (u_camera_source_model.exp_q.size() != 0) begin
                pix_e = u_camera_source_model.exp_q.pop_front();
                `CHK(pix, pix_e)
            end
        end
    end
    // one write cycle, then one idle cycle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask : wr
    // one read cycle; the monitor checks the masked word
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
        rd_q.push_back({m, e & m});
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
    endtask : rd
    // one frame of nb bytes, then every noted pixel must have arrived
    task automatic frm(input bit fwd, input int nb);
        u_camera_source_model.frame(1, nb, fwd);
        repeat (12) @(posedge clk);
        #1;
        `CHK(u_camera_source_model.exp_q.size(), 0)
    endtask : frm
    // frame with the interrupt looked at mid-frame and after the frame
    task automatic ifrm(input bit fwd, input logic mid, input logic fin);
        fork
            frm(fwd, 8);
            begin
                #1005;
                `CHK(frame_interrupt, mid)
            end
        join
        `CHK(frame_interrupt, fin)
    endtask : ifrm
    // soft reset, frame control, mode
    task automatic setup(input logic [DATA_W-1:0] fc, input logic [DATA_W-1:0] md);
        wr(OFS_COMMAND, 16'h0001);
        wr(OFS_FRAME_CTRL, fc);
        wr(OFS_MODE, md);
    endtask : setup
    task automatic conclude();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // watchdog against a hang
    initial begin
        #1000000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
    // main sequence
    initial begin
        nrst = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(OFS_MODE, 16'hffff, MODE_RESET);
        rd(OFS_FRAME_CTRL, 16'hffff, FRAME_CTRL_RESET);
        wr(OFS_STATUS, 16'hffff);
        rd(OFS_STATUS, 16'hffff, STATUS_RESET);
        rd(OFS_COMMAND, 16'hffff, 16'h0000);
        rd(8'h30, 16'hffff, 16'h0000);
        frm(0, 8);
        // every thinning code over seven frames
        for (int c = 0; c < 8; c++) begin
            n = (c == 0 || c == 6) ? 1 : c + 1;
            setup(16'(c << FC_THIN_LO), 16'h0001);
            for (int k = 0; k < 7; k++) frm(k % n == 0 && c != 7, 4);
        end
        // per-frame interrupt on each frame-valid edge, then clear
        for (int p = 0; p < 2; p++) begin
            setup(16'h0021 | 16'(p << FC_IRQ_POL), 16'h0001);
            ifrm(1, p[0], 1'b1);
            wr(OFS_COMMAND, 16'h0000);
            `CHK(frame_interrupt, 1'b1)
            rd(OFS_STATUS, 16'h0002, 16'h0002);
            wr(OFS_COMMAND, 16'h0002);
            `CHK(frame_interrupt, 1'b0)
        end
        setup(16'h0022, 16'h0001);
        ifrm(1, 1'b0, 1'b0);
        setup(16'h0003, 16'h0001);
        ifrm(1, 1'b0, 1'b0);
        wr(OFS_COMMAND, 16'h0004);
        ifrm(1, 1'b1, 1'b1);
        // capture-end interrupt fires once
        setup(16'h0080, 16'h0001);
        ifrm(1, 1'b0, 1'b0);
        wr(OFS_MODE, 16'h0000);
        ifrm(0, 1'b0, 1'b1);
        wr(OFS_COMMAND, 16'h0002);
        ifrm(0, 1'b0, 1'b0);
        // stop and start commands
        setup(16'h0000, 16'h0001);
        wr(OFS_COMMAND, 16'h0008);
        rd(OFS_STATUS, 16'h0004, 16'h0000);
        frm(0, 4);
        wr(OFS_COMMAND, 16'h0004);
        rd(OFS_STATUS, 16'h0004, 16'h0004);
        frm(1, 4);
        wr(OFS_COMMAND, 16'h0009);
        rd(OFS_STATUS, 16'h0004, 16'h0000);
        rd(OFS_MODE, 16'h0001, 16'h0000);
        // single-frame capture
        setup(16'h0040, 16'h0001);
        wr(OFS_COMMAND, 16'h0004);
        rd(OFS_STATUS, 16'h0004, 16'h0004);
        frm(1, 4);
        rd(OFS_STATUS, 16'h0004, 16'h0000);
        frm(0, 4);
        // fast sampling, then soft reset keeps all but port enable
        setup(16'h0000, 16'h0401);
        rd(OFS_MODE, 16'hffff, 16'h0401);
        frm(1, 8);
        wr(OFS_COMMAND, 16'h0001);
        rd(OFS_MODE, 16'hffff, 16'h0400);
        // odd byte count raises error flag 0
        wr(OFS_MODE, 16'h0001);
        frm(1, 5);
        rd(OFS_STATUS, 16'h0100, 16'h0100);
        wr(OFS_COMMAND, 16'h0200);
        rd(OFS_STATUS, 16'h0100, 16'h0100);
        wr(OFS_COMMAND, 16'h0100);
        rd(OFS_STATUS, 16'h0100, 16'h0000);
        conclude();
    end
endmodule : camera_frame_capture_tb
